// ==== rtl/emtpc_ctrl.sv ====
`timescale 1ns/10ps
`default_nettype none
module emtpc_ctrl (
    // Clock and resets
    input wire logic clk,
    input wire logic resetn,
    input wire logic por_resetn,
    // Buffer memory port from host
    input wire emtpc_pkg::emtpc_bm_req_t bm_req,
    output logic [15:0] bm_rdata,
    output logic bm_rvalid,
    // Preset handshake bits
    input wire logic preset_request,
    output logic preset_done,
    // Energy increments from measurement
    input wire logic [2:0] energy_pulse,
    // Host program events
    input wire logic end_of_scan,
    input wire logic group_exec,
    input wire logic [6:0] group_exec_id,
    // Refresh and indicators
    output logic refresh_pulse,
    output logic [emtpc_pkg::LED_COUNT-1:0] indicator_led,
    output logic test_mode
);

    // Pseudo-value for any word address in test mode
    function automatic logic [15:0] pseudo_word(input logic [15:0] addr);
        pseudo_word = addr ^ emtpc_pkg::PSEUDO_MASK;
    endfunction

    // Count up one unit, wrapping past the largest total
    function automatic logic [31:0] bump(input logic [31:0] v);
        bump = (v >= emtpc_pkg::PRESET_MAX) ? 32'h00000000 : v + 32'h00000001;
    endfunction

    // Retained storage: survives host CPU reset, cleared only at power-on
    emtpc_pkg::emtpc_totals_t tot_q, tot_d;
    logic [15:0] tgt_q, tgt_d;
    logic [31:0] pval_q, pval_d;
    logic ref_sel_q, ref_sel_d;
    logic [6:0] ref_grp_q, ref_grp_d;
    emtpc_pkg::emtpc_mode_t mode_param_q, mode_param_d;
    logic [1:0] err_q, err_d;

    // Control state: cleared by host CPU reset
    emtpc_pkg::emtpc_pst_t st_q, st_d;
    logic done_q, done_d;
    logic started_q, started_d;
    emtpc_pkg::emtpc_mode_t mode_q, mode_d;
    logic refresh_q, refresh_d;
    logic [15:0] rdata_q, rdata_d;
    logic rvalid_q, rvalid_d;

    logic apply;
    logic in_range;
    logic tgt_ok;
    logic is_test;

    assign is_test = (mode_q == emtpc_pkg::MODE_TEST);
    assign apply = (st_q == emtpc_pkg::ST_APPLY);
    assign in_range = (pval_q <= emtpc_pkg::PRESET_MAX);
    assign tgt_ok = (tgt_q <= emtpc_pkg::TGT_LAG);

    // Retained next values; frozen in test mode so measuring mode resumes intact
    always_comb begin
        tot_d = tot_q;
        tgt_d = tgt_q;
        pval_d = pval_q;
        ref_sel_d = ref_sel_q;
        ref_grp_d = ref_grp_q;
        mode_param_d = mode_param_q;
        err_d = err_q;
        // Mode parameter stays writable so test mode can be left again
        if (bm_req.wr && bm_req.addr == emtpc_pkg::BM_MODE_PARAM) begin
            mode_param_d = bm_req.wdata[0] ? emtpc_pkg::MODE_TEST : emtpc_pkg::MODE_MEASURE;
        end
        if (started_q && !is_test) begin
            if (energy_pulse[0]) begin
                tot_d.cons = bump(tot_q.cons);
            end
            if (energy_pulse[1]) begin
                tot_d.regen = bump(tot_q.regen);
            end
            if (energy_pulse[2]) begin
                tot_d.lag = bump(tot_q.lag);
            end
            if (bm_req.wr) begin
                unique case (bm_req.addr)
                    emtpc_pkg::BM_PRESET_TARGET: tgt_d = bm_req.wdata;
                    emtpc_pkg::BM_PRESET_VAL_LO: pval_d[15:0] = bm_req.wdata;
                    emtpc_pkg::BM_PRESET_VAL_HI: pval_d[31:16] = bm_req.wdata;
                    emtpc_pkg::BM_REFRESH_SEL: ref_sel_d = bm_req.wdata[0];
                    emtpc_pkg::BM_REFRESH_GROUP: begin
                        // Out-of-range group numbers are ignored
                        if (bm_req.wdata[6:0] >= emtpc_pkg::REFRESH_GROUP_MIN &&
                            bm_req.wdata[6:0] <= emtpc_pkg::REFRESH_GROUP_MAX &&
                            bm_req.wdata[15:7] == 9'h000) begin
                            ref_grp_d = bm_req.wdata[6:0];
                        end
                    end
                    emtpc_pkg::BM_ERROR_INFO: err_d = err_q & ~bm_req.wdata[1:0];
                    default: begin
                    end
                endcase
            end
            // Preset load uses the output scaling directly, no conversion
            if (apply) begin
                if (!in_range) begin
                    err_d[emtpc_pkg::ERR_RANGE_BIT] = 1'b1;
                end else if (!tgt_ok) begin
                    err_d[emtpc_pkg::ERR_TARGET_BIT] = 1'b1;
                end else begin
                    unique case (tgt_q[1:0])
                        2'h1: tot_d.cons = pval_q;
                        2'h2: tot_d.regen = pval_q;
                        2'h3: tot_d.lag = pval_q;
                        2'h0: begin
                        end
                    endcase
                end
            end
        end
    end

    // Retained registers
    always_ff @(posedge clk or negedge por_resetn) begin
        if (!por_resetn) begin
            tot_q <= '0;
            tgt_q <= emtpc_pkg::TGT_NONE;
            pval_q <= 32'h00000000;
            ref_sel_q <= 1'b0;
            ref_grp_q <= emtpc_pkg::REFRESH_GROUP_RST;
            mode_param_q <= emtpc_pkg::MODE_MEASURE;
            err_q <= 2'h0;
        end else begin
            tot_q <= tot_d;
            tgt_q <= tgt_d;
            pval_q <= pval_d;
            ref_sel_q <= ref_sel_d;
            ref_grp_q <= ref_grp_d;
            mode_param_q <= mode_param_d;
            err_q <= err_d;
        end
    end

    // Control next values: start-up mode capture, preset handshake, refresh
    always_comb begin
        started_d = 1'b1;
        mode_d = mode_q;
        st_d = st_q;
        done_d = done_q;
        // Mode is adopted only on the first cycle after the CPU reset
        if (!started_q) begin
            mode_d = mode_param_q;
        end
        unique case (st_q)
            emtpc_pkg::ST_IDLE: begin
                if (preset_request && started_q) begin
                    st_d = emtpc_pkg::ST_APPLY;
                end
            end
            emtpc_pkg::ST_APPLY: begin
                st_d = emtpc_pkg::ST_DONE;
                done_d = 1'b1;
            end
            emtpc_pkg::ST_DONE: begin
                // Stays here while request is high, so one apply per assertion
                if (!preset_request) begin
                    st_d = emtpc_pkg::ST_IDLE;
                    done_d = 1'b0;
                end
            end
            default: begin
                st_d = emtpc_pkg::ST_IDLE;
                done_d = 1'b0;
            end
        endcase
        // Refresh trigger follows the selected timing source
        if (!ref_sel_q) begin
            refresh_d = started_q && end_of_scan;
        end else begin
            refresh_d = started_q && group_exec && (group_exec_id == ref_grp_q);
        end
    end

    // Buffer read data; test mode answers every mapped word except the mode parameter with a pseudo-value
    always_comb begin
        rvalid_d = bm_req.rd;
        rdata_d = 16'h0000;
        if (bm_req.rd) begin
            unique case (bm_req.addr)
                emtpc_pkg::BM_CONS_LO: rdata_d = tot_q.cons[15:0];
                emtpc_pkg::BM_CONS_HI: rdata_d = tot_q.cons[31:16];
                emtpc_pkg::BM_REGEN_LO: rdata_d = tot_q.regen[15:0];
                emtpc_pkg::BM_REGEN_HI: rdata_d = tot_q.regen[31:16];
                emtpc_pkg::BM_LAG_LO: rdata_d = tot_q.lag[15:0];
                emtpc_pkg::BM_LAG_HI: rdata_d = tot_q.lag[31:16];
                emtpc_pkg::BM_PRESET_TARGET: rdata_d = tgt_q;
                emtpc_pkg::BM_PRESET_VAL_LO: rdata_d = pval_q[15:0];
                emtpc_pkg::BM_PRESET_VAL_HI: rdata_d = pval_q[31:16];
                emtpc_pkg::BM_REFRESH_SEL: rdata_d = {15'h0000, ref_sel_q};
                emtpc_pkg::BM_REFRESH_GROUP: rdata_d = {9'h000, ref_grp_q};
                emtpc_pkg::BM_ERROR_INFO: rdata_d = {14'h0000, err_q};
                emtpc_pkg::BM_MODE_PARAM: rdata_d = {15'h0000, mode_param_q};
                emtpc_pkg::BM_STATUS: rdata_d = {12'h000, done_q, st_q, mode_q};
                default: rdata_d = 16'h0000;
            endcase
            // Settings and error words are masked too, so do not drive plant from them
            if (is_test && bm_req.addr <= emtpc_pkg::BM_STATUS &&
                bm_req.addr != emtpc_pkg::BM_MODE_PARAM) begin
                rdata_d = pseudo_word(bm_req.addr);
            end
        end
    end

    // Control registers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            started_q <= 1'b0;
            mode_q <= emtpc_pkg::MODE_MEASURE;
            st_q <= emtpc_pkg::ST_IDLE;
            done_q <= 1'b0;
            refresh_q <= 1'b0;
            rdata_q <= 16'h0000;
            rvalid_q <= 1'b0;
        end else begin
            started_q <= started_d;
            mode_q <= mode_d;
            st_q <= st_d;
            done_q <= done_d;
            refresh_q <= refresh_d;
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    // Outputs; LEDs all lit in test mode, else run and error
    assign preset_done = done_q;
    assign refresh_pulse = refresh_q;
    assign bm_rdata = rdata_q;
    assign bm_rvalid = rvalid_q;
    assign test_mode = is_test;
    assign indicator_led = is_test ? {emtpc_pkg::LED_COUNT{1'b1}} :
        {2'b00, (err_q != 2'h0), started_q};

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn || !por_resetn);

    preset_done_rise_a: assert property (
        (st_q == emtpc_pkg::ST_IDLE && preset_request && started_q) |=> ##1 preset_done)
        else $error("preset done did not rise two cycles after request");

    done_drop_a: assert property (
        (preset_done && !preset_request) |=> !preset_done)
        else $error("preset done held after request dropped");

    single_apply_a: assert property (
        (apply) |=> !apply [*2])
        else $error("preset applied twice for one request");

    preset_load_cons_a: assert property (
        (apply && !is_test && in_range && tgt_q == emtpc_pkg::TGT_CONS)
        |=> (tot_q.cons == $past(pval_q)))
        else $error("consumed total not loaded with preset value");

    target_none_keep_a: assert property (
        (apply && tgt_q == emtpc_pkg::TGT_NONE && energy_pulse == 3'b000)
        |=> $stable(tot_q))
        else $error("target none changed a total");

    mode_hold_a: assert property (
        started_q |=> $stable(mode_q))
        else $error("mode changed without a CPU reset");

    test_led_a: assert property (
        is_test |-> (indicator_led == {emtpc_pkg::LED_COUNT{1'b1}}))
        else $error("LEDs not all lit in test mode");

    test_pseudo_a: assert property (
        (is_test && bm_req.rd && bm_req.addr == emtpc_pkg::BM_ERROR_INFO)
        |=> bm_rvalid && bm_rdata == pseudo_word(emtpc_pkg::BM_ERROR_INFO))
        else $error("error word not replaced by pseudo-value");

    test_freeze_a: assert property (
        (started_q && is_test) |=> $stable(tot_q) && $stable(ref_grp_q))
        else $error("retained values changed in test mode");

    scan_refresh_a: assert property (
        (started_q && !ref_sel_q && end_of_scan) |=> refresh_pulse)
        else $error("no refresh after end of scan");

    group_refresh_a: assert property (
        (started_q && ref_sel_q && group_exec && group_exec_id == ref_grp_q)
        |=> refresh_pulse)
        else $error("no refresh after the selected group ran");

    preset_cov_c: cover property (apply ##1 preset_done ##[1:20] !preset_done);
    led_err_cov_c: cover property (!is_test && indicator_led[1]);
    group_cov_c: cover property (ref_sel_q && refresh_pulse);
    test_cov_c: cover property (is_test && bm_rvalid);
    range_cov_c: cover property (apply && !in_range);

endmodule
`default_nettype wire

// ==== rtl/emtpc_pkg.sv ====
// Functional notes
// - End-of-scan timing copies measurement buffer sections each time host program ends.
// - Host may overwrite any energy total; loading zero clears it.
// - Target word 0 none, 1 consumed, 2 regenerated, 3 lagging reactive energy.
// - Preset value uses the same unit and scaling as the output totals.
// - On preset request, apply selected target and value, then raise preset done.
// - Device drops preset done once it sees the request dropped.
// - Mode change takes effect only at start-up after the host CPU reset.
// - Test mode lights every indicator LED and fills buffer with pseudo-values.
// - Test mode also substitutes pseudo-values for settings and error information.
// - Returning to measuring mode keeps settings and totals from before test mode.
package emtpc_pkg;

    // Buffer word offsets (16-bit words)
    localparam logic [15:0] BM_CONS_LO = 16'h0000;
    localparam logic [15:0] BM_CONS_HI = 16'h0001;
    localparam logic [15:0] BM_REGEN_LO = 16'h0002;
    localparam logic [15:0] BM_REGEN_HI = 16'h0003;
    localparam logic [15:0] BM_LAG_LO = 16'h0004;
    localparam logic [15:0] BM_LAG_HI = 16'h0005;
    localparam logic [15:0] BM_PRESET_TARGET = 16'h0033;
    localparam logic [15:0] BM_PRESET_VAL_LO = 16'h0034;
    localparam logic [15:0] BM_PRESET_VAL_HI = 16'h0035;
    localparam logic [15:0] BM_REFRESH_SEL = 16'h0036;
    localparam logic [15:0] BM_REFRESH_GROUP = 16'h0037;
    localparam logic [15:0] BM_ERROR_INFO = 16'h0038;
    localparam logic [15:0] BM_MODE_PARAM = 16'h0039;
    localparam logic [15:0] BM_STATUS = 16'h003A;

    // Preset target codes
    localparam logic [15:0] TGT_NONE = 16'h0000;
    localparam logic [15:0] TGT_CONS = 16'h0001;
    localparam logic [15:0] TGT_REGEN = 16'h0002;
    localparam logic [15:0] TGT_LAG = 16'h0003;

    // Limits and reset values
    localparam logic [31:0] PRESET_MAX = 32'h05F5E0FF;
    localparam logic [6:0] REFRESH_GROUP_MIN = 7'h01;
    localparam logic [6:0] REFRESH_GROUP_MAX = 7'h40;
    localparam logic [6:0] REFRESH_GROUP_RST = 7'h01;
    localparam logic [15:0] PSEUDO_MASK = 16'h5A5A;
    localparam int ERR_RANGE_BIT = 0;
    localparam int ERR_TARGET_BIT = 1;
    localparam int LED_COUNT = 4;

    typedef enum logic {
        MODE_MEASURE,
        MODE_TEST
    } emtpc_mode_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_APPLY,
        ST_DONE
    } emtpc_pst_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [15:0] wdata;
    } emtpc_bm_req_t;

    typedef struct packed {
        logic [31:0] lag;
        logic [31:0] regen;
        logic [31:0] cons;
    } emtpc_totals_t;

endpackage

// ==== verification/emtpc_host_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module emtpc_host_model (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Command from the bench
    input wire logic go,
    input wire logic [3:0] hold,
    // Handshake bits
    input wire logic preset_done,
    output logic preset_request,
    output logic busy
);
    logic [3:0] cnt;

    // Host side of the preset handshake, moving only on the falling edge
    always @(negedge clk or negedge resetn) begin
        if (!resetn) begin
            preset_request <= 1'b0;
            busy <= 1'b0;
            cnt <= 4'h0;
        end else if (!busy) begin
            if (go) begin
                preset_request <= 1'b1;
                busy <= 1'b1;
                cnt <= hold;
            end
        end else if (preset_request) begin
            // A slow host lingers after done, to expose a repeated apply
            if (preset_done && cnt == 4'h0) begin
                preset_request <= 1'b0;
            end else if (preset_done) begin
                cnt <= cnt - 4'h1;
            end
        end else if (!preset_done) begin
            busy <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ==== verification/tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic por_resetn = 1'b0;
    emtpc_pkg::emtpc_bm_req_t bm_req = '0;
    logic [15:0] bm_rdata;
    logic bm_rvalid, preset_request, preset_done, refresh_pulse, test_mode, busy;
    logic go = 1'b0;
    logic [3:0] hold = 4'h1;
    logic [2:0] energy_pulse = 3'h0;
    logic end_of_scan = 1'b0;
    logic group_exec = 1'b0;
    logic [6:0] group_exec_id = 7'h00;
    logic [emtpc_pkg::LED_COUNT-1:0] indicator_led;
    logic [31:0] tot [3];
    integer seed = 32'h189A;
    int failures = 0;
    int check_count = 0;
    int cycles = 0;

    // Clock at 200 MHz
    always #2.5 clk = ~clk;

    emtpc_ctrl uut (.clk(clk), .resetn(resetn), .por_resetn(por_resetn), .bm_req(bm_req),
        .bm_rdata(bm_rdata), .bm_rvalid(bm_rvalid), .preset_request(preset_request),
        .preset_done(preset_done), .energy_pulse(energy_pulse), .end_of_scan(end_of_scan),
        .group_exec(group_exec), .group_exec_id(group_exec_id),
        .refresh_pulse(refresh_pulse), .indicator_led(indicator_led), .test_mode(test_mode));

    emtpc_host_model host (.clk(clk), .resetn(resetn), .go(go), .hold(hold),
        .preset_done(preset_done), .preset_request(preset_request), .busy(busy));

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // Hang guard, far above the few hundred cycles the tests need
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            end_of_test();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        bm_req.wr <= 1'b1;
        bm_req.addr <= a;
        bm_req.wdata <= d;
        @(negedge clk);
        bm_req.wr <= 1'b0;
        // Idle cycle, so a following call never re-drives the strobe in one step
        @(negedge clk);
    endtask

    // Totals roll over to zero past the largest preset value
    function automatic logic [31:0] next_total(input logic [31:0] v);
        next_total = (v >= emtpc_pkg::PRESET_MAX) ? 32'h00000000 : v + 32'h00000001;
    endfunction

    // Read answer is looked at in the one cycle it stands
    task automatic rd(input logic [15:0] a, input logic [15:0] e);
        bm_req.rd <= 1'b1;
        bm_req.addr <= a;
        @(negedge clk);
        bm_req.rd <= 1'b0;
        chk(32'(bm_rvalid), 32'h1);
        chk(32'(bm_rdata), 32'(e));
        @(negedge clk);
    endtask

    task automatic rd_totals;
        int i;
        for (i = 0; i < 3; i++) begin
            rd(16'(2 * i), tot[i][15:0]);
            rd(16'(2 * i + 1), tot[i][31:16]);
        end
    endtask

    task automatic fire(input logic eos, input logic gx, input logic [6:0] id, input logic e);
        end_of_scan <= eos;
        group_exec <= gx;
        group_exec_id <= id;
        @(negedge clk);
        end_of_scan <= 1'b0;
        group_exec <= 1'b0;
        chk(32'(refresh_pulse), 32'(e));
        @(negedge clk);
    endtask

    // One full handshake; all totals count once while request is still high
    task automatic preset(input logic [15:0] tgt, input logic [31:0] val);
        int n;
        wr(emtpc_pkg::BM_PRESET_TARGET, tgt);
        wr(emtpc_pkg::BM_PRESET_VAL_LO, val[15:0]);
        wr(emtpc_pkg::BM_PRESET_VAL_HI, val[31:16]);
        hold <= 4'({$random(seed)} % 8 + 1);
        go <= 1'b1;
        @(negedge clk);
        go <= 1'b0;
        for (n = 0; n < 20 && preset_done !== 1'b1; n++) @(negedge clk);
        chk(32'(preset_done), 32'h1);
        energy_pulse <= 3'h7;
        @(negedge clk);
        energy_pulse <= 3'h0;
        for (n = 0; n < 40 && busy; n++) @(negedge clk);
        chk(32'(preset_done), 32'h0);
        if (tgt >= 16'h1 && tgt <= 16'h3 && val <= emtpc_pkg::PRESET_MAX) tot[tgt-1] = val;
        for (n = 0; n < 3; n++) tot[n] = next_total(tot[n]);
        rd_totals();
    endtask

    task automatic cpu_reset;
        resetn <= 1'b0;
        repeat (3) @(negedge clk);
        resetn <= 1'b1;
        repeat (3) @(negedge clk);
    endtask

    // Main sequence
    initial begin
        int i;
        logic [6:0] g;
        for (i = 0; i < 3; i++) tot[i] = 32'h0;
        repeat (20) @(negedge clk);
        por_resetn <= 1'b1;
        resetn <= 1'b1;
        repeat (3) @(negedge clk);
        chk(32'(indicator_led), 32'h1);
        rd(emtpc_pkg::BM_REFRESH_GROUP, 16'h0001);
        rd(16'h0040, 16'h0000);
        fire(1'b1, 1'b0, 7'h01, 1'b1);
        fire(1'b0, 1'b1, 7'h01, 1'b0);
        g = 7'({$random(seed)} % 64 + 1);
        wr(emtpc_pkg::BM_REFRESH_SEL, 16'h0001);
        wr(emtpc_pkg::BM_REFRESH_GROUP, {9'h000, g});
        wr(emtpc_pkg::BM_REFRESH_GROUP, 16'h0000);
        wr(emtpc_pkg::BM_REFRESH_GROUP, 16'h0041);
        rd(emtpc_pkg::BM_REFRESH_GROUP, {9'h000, g});
        fire(1'b0, 1'b1, g, 1'b1);
        fire(1'b0, 1'b1, 7'(g % 64 + 1), 1'b0);
        fire(1'b1, 1'b0, 7'h00, 1'b0);
        wr(emtpc_pkg::BM_REFRESH_SEL, 16'h0000);
        $display("test refresh done");
        preset(emtpc_pkg::TGT_CONS, emtpc_pkg::PRESET_MAX);
        preset(emtpc_pkg::TGT_REGEN, 32'h0000_0000);
        preset(emtpc_pkg::TGT_NONE, 32'h0000_1234);
        preset(emtpc_pkg::TGT_LAG, emtpc_pkg::PRESET_MAX + 32'h1);
        rd(emtpc_pkg::BM_ERROR_INFO, 16'h0001);
        for (i = 0; i < 8; i++) begin
            preset(16'({$random(seed)} % 4), {$random(seed)} % 100000000);
        end
        $display("test preset done");
        wr(emtpc_pkg::BM_MODE_PARAM, 16'h0001);
        chk(32'(test_mode), 32'h0);
        cpu_reset();
        chk(32'(test_mode), 32'h1);
        chk(32'(indicator_led), 32'((1 << emtpc_pkg::LED_COUNT) - 1));
        rd(emtpc_pkg::BM_CONS_LO, 16'h5A5A);
        rd(emtpc_pkg::BM_ERROR_INFO, 16'h0038 ^ 16'h5A5A);
        rd(emtpc_pkg::BM_REFRESH_GROUP, 16'h0037 ^ 16'h5A5A);
        wr(emtpc_pkg::BM_REFRESH_GROUP, {9'h000, 7'(g % 64 + 1)});
        energy_pulse <= 3'h7;
        @(negedge clk);
        energy_pulse <= 3'h0;
        wr(emtpc_pkg::BM_MODE_PARAM, 16'h0000);
        cpu_reset();
        chk(32'(test_mode), 32'h0);
        chk(32'(indicator_led), 32'h3);
        rd_totals();
        rd(emtpc_pkg::BM_REFRESH_GROUP, {9'h000, g});
        rd(emtpc_pkg::BM_ERROR_INFO, 16'h0001);
        $display("test mode done");
        end_of_test();
    end
endmodule
`default_nettype wire
